// *** bench/ce_engine_bench.sv ***
// Self-checking bench of the CRC engine: registers, programmed input and feed transfers.
// Assumes the engine on an APB master and the memory model on its feed port.
`timescale 1ns/1ps
`include "ce_map.svh"

module ce_engine_bench;
    import ce_pkg::*;
    logic clk;
    logic srst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [`CE_AW-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ce_dma_req_s feed_req;
    ce_dma_rsp_s feed_rsp;
    logic [3:0] delay;
    logic [31:0] err_addr;
    logic [31:0] q;
    logic [31:0] run;
    logic [31:0] seed_v;
    logic [3:0] f;
    logic last_err;
    int n_errors;
    int num_checks;

    ce_engine DUT (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .feed_req(feed_req), .feed_rsp(feed_rsp));
    ce_mem_model mem (.clk(clk), .srst(srst), .feed_req(feed_req), .feed_rsp(feed_rsp),
        .delay(delay), .err_addr(err_addr));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [`CE_AW-1:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_errors++;
            summarize();
        end
    endtask

    task automatic rdc(input logic [`CE_AW-1:0] a, input logic [31:0] e, input string name);
        apb(1'b0, a, 32'h0);
        chk(name, q, e);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, `CE_OFF_CTL, 32'h0);
            n++;
        end while (q[`CE_F_TRIG] !== 1'b0 && n < 200);
        if (q[`CE_F_TRIG] !== 1'b0) begin
            n_errors++;
            summarize();
        end
    endtask

    function automatic logic [31:0] cw(input logic [1:0] m, input logic [5:0] fl,
        input logic t, input logic [1:0] re);
        return {m, fl, t, 21'h0, re};
    endfunction

    function automatic int wid(input logic [1:0] m);
        return (m == 2'b01) ? 8 : (m == 2'b11) ? 32 : 16;
    endfunction

    function automatic logic [31:0] wmask(input logic [1:0] m);
        return (m == 2'b11) ? 32'hFFFF_FFFF : (32'h1 << wid(m)) - 32'h1;
    endfunction

    function automatic logic [31:0] fold(input logic [31:0] c, input logic [31:0] d,
        input int nb, input logic [1:0] m);
        logic [31:0] poly;
        logic fb;
        poly = (m == 2'b00) ? 32'h0000_1021 : (m == 2'b01) ? 32'h0000_0007 :
            (m == 2'b10) ? 32'h0000_8005 : 32'h04C1_1DB7;
        for (int i = nb - 1; i >= 0; i--) begin
            fb = c[wid(m) - 1] ^ d[i];
            c = ((c << 1) & wmask(m)) ^ (fb ? poly : 32'h0);
        end
        return c & wmask(m);
    endfunction

    function automatic logic [31:0] shown(input logic [31:0] c, input logic [1:0] m,
        input logic flip, input logic inv);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < wid(m); i++) begin
            r[i] = flip ? c[wid(m) - 1 - i] : c[i];
        end
        return inv ? r ^ wmask(m) : r;
    endfunction

    function automatic logic [31:0] xin(input logic [31:0] d, input logic inv, input logic flip);
        logic [31:0] r;
        r = inv ? ~d : d;
        for (int i = 0; i < 32; i++) begin
            d[i] = flip ? r[(i & ~7) + 7 - (i & 7)] : r[i];
        end
        return d;
    endfunction

    task automatic feed(input logic [31:0] src, input logic [15:0] len, input logic [1:0] m);
        apb(1'b1, `CE_OFF_SRC, src);
        apb(1'b1, `CE_OFF_BCNT, {16'hFFFF, len});
        rdc(`CE_OFF_BCNT, {16'h0, len}, "byte count");
        apb(1'b1, `CE_OFF_CTL, cw(m, 6'h0, 1'b1, 2'b01));
        run = seed_v & wmask(m);
        for (int b = 0; b < len; b += 4) begin
            run = fold(run, mword(src + 32'(b)), (len - b >= 4) ? 32 : (len - b) * 8, m);
        end
    endtask

    function automatic logic [31:0] mword(input logic [31:0] a);
        return {a[7:0], ~a[7:0], a[7:0] ^ 8'h5A, 8'hC3};
    endfunction

    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        delay = 4'h0;
        err_addr = 32'hFFFF_FFFF;
        n_errors = 0;
        num_checks = 0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rdc(`CE_OFF_CTL, 32'h2000_0000, "ctl reset");
        rdc(`CE_OFF_SRC, 32'h0, "src reset");
        rdc(`CE_OFF_BCNT, 32'h0, "bcnt reset");
        rdc(`CE_OFF_CUR, 32'h0, "cur reset");
        rdc(`CE_OFF_SEED, 32'hFFFF_FFFF, "seed reset");
        apb(1'b0, 12'h040, 32'h0);
        chk("unmapped error", {31'h0, last_err}, 32'h1);
        $display("test reset done");
        seed_v = 32'h1234_ABCD;
        apb(1'b1, `CE_OFF_SEED, seed_v);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, `CE_OFF_CTL, cw(2'(m), 6'h20, 1'b0, 2'b11));
            repeat (6) @(posedge clk);
            rdc(`CE_OFF_CTL, cw(2'(m), 6'h20, 1'b0, 2'b01), "ctl self clear");
            run = seed_v & wmask(2'(m));
            for (int w = 0; w < 3; w++) begin
                f = 4'(m * 3 + w);
                apb(1'b1, `CE_OFF_CTL, cw(2'(m), {2'(w), f}, 1'b0, 2'b01));
                apb(1'b1, `CE_OFF_WDATA, 32'h89AB_CDEF);
                run = fold(run, xin(32'h89AB_CDEF, f[2], f[0]), 8 << w, 2'(m));
                rdc(`CE_OFF_SUM, shown(run, 2'(m), f[1], f[3]), "pio sum");
            end
        end
        apb(1'b1, `CE_OFF_CTL, cw(2'b11, 6'h20, 1'b0, 2'b00));
        apb(1'b1, `CE_OFF_WDATA, 32'h0F0F_0F0F);
        rdc(`CE_OFF_SUM, run, "disabled sum");
        apb(1'b1, `CE_OFF_CTL, cw(2'b11, 6'h31, 1'b0, 2'b01));
        apb(1'b1, `CE_OFF_WDATA, 32'hAABB_CCDD);
        rdc(`CE_OFF_WDATA, 32'h55DD_33BB, "wdata flip");
        run = fold(run, 32'h55DD_33BB, 32, 2'b11);
        rdc(`CE_OFF_SUM, run, "wide sum");
        $display("test programmed input done");
        for (int m = 0; m < 4; m++) begin
            delay <= 4'(m * 3);
            feed(32'h100 + 32'(m * 64), 16'(m * 5 + 3), 2'(m));
            wait_idle();
            rdc(`CE_OFF_FLAG, 32'h2, "done flag");
            rdc(`CE_OFF_CUR, 32'h100 + 32'(m * 64 + ((m * 5 + 2) / 4) * 4), "cur");
            rdc(`CE_OFF_REM, 32'h0, "remaining");
            rdc(`CE_OFF_SUM, run, "feed sum");
            apb(1'b1, `CE_OFF_FLAG, 32'h2);
            rdc(`CE_OFF_FLAG, 32'h0, "done cleared");
        end
        $display("test feed done");
        delay <= 4'h8;
        feed(32'h200, 16'd32, 2'b10);
        apb(1'b1, `CE_OFF_WDATA, 32'h1357_9BDF);
        apb(1'b1, `CE_OFF_CTL, cw(2'b10, 6'h0, 1'b0, 2'b00));
        wait_idle();
        rdc(`CE_OFF_FLAG, 32'h0, "no done");
        rdc(`CE_OFF_SUM, run, "sum after disable");
        $display("test disable mid feed done");
        delay <= 4'h1;
        err_addr <= 32'h30C;
        feed(32'h300, 16'd16, 2'b11);
        wait_idle();
        rdc(`CE_OFF_FLAG, 32'h1, "bus error");
        apb(1'b1, `CE_OFF_FLAG, 32'h1);
        rdc(`CE_OFF_FLAG, 32'h0, "error cleared");
        apb(1'b1, `CE_OFF_CTL, cw(2'b11, 6'h0, 1'b0, 2'b11));
        err_addr <= 32'hFFFF_FFFF;
        $display("test bus error done");
        delay <= 4'h8;
        feed(32'h400, 16'd64, 2'b11);
        apb(1'b1, `CE_OFF_CTL, cw(2'b11, 6'h0, 1'b0, 2'b11));
        repeat (6) @(posedge clk);
        rdc(`CE_OFF_CTL, cw(2'b11, 6'h0, 1'b0, 2'b01), "abort");
        rdc(`CE_OFF_REM, 32'h0, "abort remaining");
        rdc(`CE_OFF_FLAG, 32'h0, "abort flags");
        rdc(`CE_OFF_SUM, seed_v, "seed reload");
        $display("test abort done");
        summarize();
    end
endmodule // ce_engine_bench

// *** bench/ce_mem_model.sv ***
// Memory model on the CRC engine's feed port: answers each read after a set delay.
// Assumes requests are held until answered, on the engine's clock.
`timescale 1ns/1ps

module ce_mem_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Feed port.
    input wire ce_pkg::ce_dma_req_s feed_req,
    output ce_pkg::ce_dma_rsp_s feed_rsp,
    // Answer delay and failing address.
    input wire logic [3:0] delay,
    input wire logic [31:0] err_addr
);
    import ce_pkg::*;
    logic [3:0] cnt;
    logic ack;
    logic err;
    logic [31:0] word;
    // Outside an answer the data lines carry the inverse of the last word.
    assign feed_rsp = '{ack: ack, err: err, rdata: ack ? word : ~word};
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt <= 4'h0;
            ack <= 1'b0;
            err <= 1'b0;
            word <= 32'h0;
        end else if (ack) begin
            cnt <= 4'h0;
            ack <= 1'b0;
            err <= 1'b0;
        end else if (feed_req.req && cnt >= delay) begin
            ack <= 1'b1;
            err <= (feed_req.addr == err_addr);
            word <= {feed_req.addr[7:0], ~feed_req.addr[7:0], feed_req.addr[7:0] ^ 8'h5A,
                8'hC3};
        end else if (feed_req.req) begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule // ce_mem_model

// *** src/ce_crc_fold.sv ***
// Folds up to 32 data bits, most significant valid bit first, into a running CRC.
// Assumes the running value and polynomial are left aligned in 32 bits.
`timescale 1ns/1ps
`include "ce_map.svh"

module ce_crc_fold (
    // Running value and data.
    input wire logic [31:0] crc_in,
    input wire logic [31:0] data,
    input wire logic [5:0] nbits,
    // Polynomial choice.
    input wire logic [1:0] mode,
    // Folded value.
    output logic [31:0] crc_out
);
    import ce_pkg::*;

    logic [31:0] poly;

    always_comb begin
        case (mode) // [R1]
            2'b00: poly = `CE_POLY_CCITT;
            2'b01: poly = `CE_POLY_8;
            2'b10: poly = `CE_POLY_16;
            default: poly = `CE_POLY_32;
        endcase
    end

    always_comb begin
        logic [31:0] c;
        logic fb;
        c = crc_in;
        fb = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if (i < int'(nbits)) begin // [R22]
                fb = c[31] ^ data[5'(int'(nbits) - 1 - i)];
                c = {c[30:0], 1'b0} ^ (fb ? poly : 32'h0);
            end
        end
        crc_out = c;
    end

endmodule // ce_crc_fold

// *** src/ce_engine.sv ***
// CRC engine with programmed-I/O input and a memory-reading feed, APB register slave.
// Assumes one clock, a same-clock memory port and software that programs aligned addresses.
//
// Operation
// R1: Bits 31:30 pick CCITT, 8-bit, 16-bit or 32-bit polynomial.
// R2: In programmed-I/O mode bits 29:28 give input width 8, 16 or 32.
// R3: Narrow widths use only the low 8 or 16 bits of the word.
// R4: Bit 27 presents the ones' complement of the checksum.
// R5: Bit 26 complements each input word before folding.
// R6: Bit 25 reverses the bit order of the whole checksum.
// R7: Bit 24 reverses bits within each input byte, bytes keep place.
// R8: Bit 23 starts a feed transfer and clears itself when done.
// R9: Software writes no input data while the feed trigger is set.
// R10: A bus error stops feed transfers; software resets before retriggering.
// R11: Bit 1 resets engine state, keeps control, clears itself shortly.
// R12: Engine reset reloads the seed into the running CRC.
// R13: Bit 0 enables the engine; it calculates only while set.
// R14: Enable cleared mid-transfer: finish, keep trigger, raise no done flag; the code clears the trigger when the transfer ends.
// R15: Engine reset aborts a feed transfer at once.
// R16: Feed start address comes from a 32-bit word-aligned register.
// R17: Feed length in bytes comes from bits 15:0 of byte count.
// R18: A finished feed sets a done flag, cleared by writing one.
// R19: A bus error sets an error flag, stops, returns to idle.
// R20: Seed register sets the starting CRC, all ones after reset.
// R21: Address of the latest feed read is readable.
// R22: Each accepted word is folded and the transformed checksum is readable.
// R23: Feed advances one word per fetch, counts bytes down, ends at zero.
`timescale 1ns/1ps
`include "ce_map.svh"

module ce_engine (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`CE_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Memory read port of the feed.
    output ce_pkg::ce_dma_req_s feed_req,
    input wire ce_pkg::ce_dma_rsp_s feed_rsp
);
    import ce_pkg::*;

    ce_regs_s r;
    ce_regs_s next_r;
    logic fold_go;
    logic [31:0] fold_data;
    logic [5:0] fold_bits;
    logic [31:0] fold_out;

    function automatic logic [4:0] align_shift(input logic [1:0] mode);
        case (mode)
            2'b01: align_shift = 5'h18;
            2'b11: align_shift = 5'h00;
            default: align_shift = 5'h10;
        endcase
    endfunction

    function automatic logic [31:0] in_xform(input logic [31:0] d, input ce_ctl_s c);
        logic [31:0] x;
        logic [31:0] y;
        x = c.iinv ? ~d : d; // [R5]
        y = x;
        if (c.iflip) begin // [R7]
            for (int b = 0; b < 4; b++) begin
                for (int k = 0; k < 8; k++) begin
                    y[b * 8 + k] = x[b * 8 + 7 - k];
                end
            end
        end
        in_xform = y;
    endfunction

    function automatic logic [31:0] sum_view(input logic [31:0] crc, input ce_ctl_s c);
        logic [4:0] sh;
        logic [31:0] v;
        logic [31:0] rv;
        sh = align_shift(c.mode);
        v = crc >> sh;
        for (int k = 0; k < 32; k++) begin
            rv[k] = crc[k];
        end
        for (int k = 0; k < 32; k++) begin
            rv[k] = v[31 - k];
        end
        if (c.rflip) begin // [R6]
            v = rv >> sh;
        end
        if (c.rinv) begin // [R4]
            v = v ^ (32'hFFFF_FFFF >> sh);
        end
        sum_view = v;
    endfunction

    function automatic logic [5:0] pio_bits(input logic [1:0] wlen);
        case (wlen) // [R2] [R3]
            2'b00: pio_bits = 6'h08;
            2'b01: pio_bits = 6'h10;
            default: pio_bits = 6'h20;
        endcase
    endfunction

    ce_crc_fold u_fold (
        .crc_in(r.crc),
        .data(fold_data),
        .nbits(fold_bits),
        .mode(r.ctl.mode),
        .crc_out(fold_out)
    );

    always_comb begin
        logic wr;
        logic setup;
        logic [15:0] take;
        logic [31:0] rd;
        wr = psel && penable && pwrite;
        setup = psel && !penable;
        take = 16'h0;
        rd = 32'h0;
        next_r = r;
        fold_go = 1'b0;
        fold_data = 32'h0;
        fold_bits = 6'h00;

        // Register reads are staged in the setup phase and shown in the access phase.
        if (setup) begin
            next_r.slverr = 1'b0;
            case (paddr)
                `CE_OFF_CTL: rd = {r.ctl.mode, r.ctl.wlen, r.ctl.rinv, r.ctl.iinv,
                    r.ctl.rflip, r.ctl.iflip, r.ctl.trig, 21'h0, r.ctl.rst, r.ctl.en};
                `CE_OFF_SRC: rd = r.src;
                `CE_OFF_BCNT: rd = {16'h0, r.bcnt};
                `CE_OFF_CUR: rd = r.cur; // [R21]
                `CE_OFF_REM: rd = {16'h0, r.rem};
                `CE_OFF_FLAG: rd = {30'h0, r.done, r.berr};
                `CE_OFF_WDATA: rd = r.wdata;
                `CE_OFF_SEED: rd = r.seed;
                `CE_OFF_SUM: rd = sum_view(r.crc, r.ctl); // [R22]
                default: next_r.slverr = 1'b1;
            endcase
            next_r.rdata = rd;
        end

        // Register writes.
        if (wr) begin
            case (paddr)
                `CE_OFF_CTL: begin
                    next_r.ctl.mode = pwdata[`CE_F_MODE];
                    next_r.ctl.wlen = pwdata[`CE_F_WLEN];
                    next_r.ctl.rinv = pwdata[`CE_F_RINV];
                    next_r.ctl.iinv = pwdata[`CE_F_IINV];
                    next_r.ctl.rflip = pwdata[`CE_F_RFLIP];
                    next_r.ctl.iflip = pwdata[`CE_F_IFLIP];
                    next_r.ctl.en = pwdata[`CE_F_EN];
                    if (pwdata[`CE_F_RST]) begin // [R11]
                        next_r.ctl.rst = 1'b1;
                        next_r.rcnt = `CE_RST_CYCLES;
                    end else if (pwdata[`CE_F_TRIG] && pwdata[`CE_F_EN] && !r.ctl.rst
                            && r.st == CE_IDLE) begin // [R8] [R13]
                        next_r.ctl.trig = 1'b1;
                        next_r.st = CE_READ;
                        next_r.addr = {r.src[31:2], 2'b00}; // [R16]
                        next_r.rem = r.bcnt; // [R17]
                        next_r.crc = r.seed << align_shift(pwdata[`CE_F_MODE]);
                    end
                end
                `CE_OFF_SRC: next_r.src = pwdata; // [R16]
                `CE_OFF_BCNT: next_r.bcnt = pwdata[`CE_F_CNT]; // [R17]
                `CE_OFF_SEED: next_r.seed = pwdata; // [R20]
                `CE_OFF_FLAG: begin
                    if (pwdata[`CE_F_DONE]) begin
                        next_r.done = 1'b0;
                    end
                    if (pwdata[`CE_F_BERR]) begin
                        next_r.berr = 1'b0;
                    end
                end
                `CE_OFF_WDATA: begin
                    // Input words are taken only in programmed-I/O mode.
                    if (r.ctl.en && !r.ctl.trig && !r.ctl.rst) begin // [R9] [R13]
                        fold_go = 1'b1;
                        fold_data = in_xform(pwdata, r.ctl);
                        fold_bits = pio_bits(r.ctl.wlen); // [R2] [R3]
                        next_r.wdata = fold_data;
                    end
                end
                default: begin
                end
            endcase
        end

        // Feed sequencer.
        case (r.st)
            CE_IDLE: begin
            end
            CE_READ: begin
                if (r.rem == 16'h0) begin // [R23]
                    next_r.st = CE_IDLE;
                    next_r.ctl.trig = 1'b0; // [R8]
                    if (r.ctl.en) begin // [R14]
                        next_r.done = 1'b1; // [R18]
                    end
                end else if (feed_rsp.ack) begin
                    next_r.cur = r.addr; // [R21]
                    if (feed_rsp.err) begin // [R19] [R10]
                        next_r.berr = 1'b1;
                        next_r.ctl.trig = 1'b0;
                        next_r.st = CE_IDLE;
                    end else begin
                        take = (r.rem > `CE_WORD_BYTES) ? `CE_WORD_BYTES : r.rem;
                        fold_go = 1'b1;
                        fold_data = in_xform(feed_rsp.rdata, r.ctl);
                        fold_bits = 6'({take[2:0], 3'b000});
                        next_r.wdata = fold_data;
                        next_r.addr = r.addr + 32'h4; // [R23]
                        next_r.rem = r.rem - take;
                    end
                end
            end
            default: begin
                next_r.st = CE_IDLE;
            end
        endcase

        if (fold_go) begin
            next_r.crc = fold_out; // [R22]
        end

        // Engine reset wins over the feed state, trigger, remaining count, input word and running CRC.
        if (r.ctl.rst) begin
            next_r.st = CE_IDLE; // [R15]
            next_r.ctl.trig = 1'b0;
            next_r.rem = 16'h0;
            next_r.wdata = 32'h0;
            next_r.crc = r.seed << align_shift(r.ctl.mode); // [R12]
            next_r.rcnt = r.rcnt - 2'h1;
            if (r.rcnt == 2'h1) begin // [R11]
                next_r.ctl.rst = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r <= '0;
            r.st <= CE_IDLE;
            r.ctl.mode <= 2'(`CE_CTL_RST >> 30);
            r.ctl.wlen <= 2'(`CE_CTL_RST >> 28);
            r.seed <= `CE_SEED_RST; // [R20]
        end else begin
            r <= next_r;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && r.slverr;
    assign prdata = r.rdata;
    assign feed_req.req = (r.st == CE_READ) && (r.rem != 16'h0) && !r.ctl.rst;
    assign feed_req.addr = r.addr;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence s_last_word;
        feed_req.req && feed_rsp.ack && !feed_rsp.err && r.rem <= `CE_WORD_BYTES;
    endsequence

    sequence s_mid_word;
        feed_req.req && feed_rsp.ack && !feed_rsp.err && r.rem > `CE_WORD_BYTES;
    endsequence

    property p_trig_clears;
        s_last_word |=> ##1 (!r.ctl.trig && r.st == CE_IDLE);
    endproperty
    a_trig_clears: assert property (p_trig_clears) else $error("trigger not cleared"); // [R8]

    property p_done_set;
        (s_last_word ##0 r.ctl.en) ##1 r.ctl.en |=> r.done;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag not set"); // [R18]

    property p_no_done;
        (s_last_word ##0 !r.ctl.en && !r.done) ##1 (!r.ctl.en && !r.ctl.rst) |=> !r.done;
    endproperty
    a_no_done: assert property (p_no_done) else $error("done set while disabled"); // [R14]

    property p_berr;
        feed_req.req && feed_rsp.ack && feed_rsp.err |=> r.berr && !r.ctl.trig && !feed_req.req;
    endproperty
    a_berr: assert property (p_berr) else $error("bus error not handled"); // [R19]

    property p_rst_clear;
        $rose(r.ctl.rst) |-> ##[1:4] !r.ctl.rst;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("engine reset stuck"); // [R11]

    property p_rst_abort;
        r.ctl.rst |=> !feed_req.req && !r.ctl.trig && r.rem == 16'h0;
    endproperty
    a_rst_abort: assert property (p_rst_abort) else $error("feed not aborted"); // [R15]

    function automatic logic wr_any();
        wr_any = psel && penable && pwrite;
    endfunction

    property p_seed_load;
        r.ctl.rst && !wr_any() |=> r.crc == ($past(r.seed) << align_shift($past(r.ctl.mode)));
    endproperty
    a_seed_load: assert property (p_seed_load) else $error("seed not reloaded"); // [R12]

    property p_addr_step;
        s_mid_word |=> feed_req.addr == $past(feed_req.addr) + 32'h4
            && r.cur == $past(feed_req.addr) && r.rem == $past(r.rem) - `CE_WORD_BYTES;
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("feed did not advance"); // [R23]

    property p_gate;
        psel && penable && pwrite && paddr == `CE_OFF_WDATA && !r.ctl.en && !r.ctl.rst
            && r.st == CE_IDLE |=> $stable(r.crc);
    endproperty
    a_gate: assert property (p_gate) else $error("disabled engine folded data"); // [R13]

    property p_addr_align;
        feed_req.req |-> feed_req.addr[1:0] == 2'b00;
    endproperty
    a_addr_align: assert property (p_addr_align) else $error("feed address not aligned"); // [R16]

    property p_wdata_refused;
        wr_any() && paddr == `CE_OFF_WDATA && r.ctl.trig && !r.ctl.rst && !feed_rsp.ack
            |=> $stable(r.wdata);
    endproperty
    a_wdata_refused: assert property (p_wdata_refused) else $error("input taken in feed"); // [R9]

    property p_done_w1c;
        wr_any() && paddr == `CE_OFF_FLAG && pwdata[`CE_F_DONE]
            && !(r.st == CE_READ && r.rem == 16'h0) |=> !r.done;
    endproperty
    a_done_w1c: assert property (p_done_w1c) else $error("done flag not cleared"); // [R18]

endmodule // ce_engine

// *** src/ce_map.svh ***
// Register offsets, field positions, reset values and polynomials of the CRC engine.
// Assumes a byte-addressed register window with one aligned 32-bit word per register.
`ifndef CE_MAP_SVH
`define CE_MAP_SVH

`define CE_AW 12
`define CE_OFF_CTL 12'h000
`define CE_OFF_SRC 12'h004
`define CE_OFF_BCNT 12'h00C
`define CE_OFF_CUR 12'h014
`define CE_OFF_REM 12'h01C
`define CE_OFF_FLAG 12'h024
`define CE_OFF_WDATA 12'h080
`define CE_OFF_SEED 12'h084
`define CE_OFF_SUM 12'h088

`define CE_F_MODE 31:30
`define CE_F_WLEN 29:28
`define CE_F_RINV 27
`define CE_F_IINV 26
`define CE_F_RFLIP 25
`define CE_F_IFLIP 24
`define CE_F_TRIG 23
`define CE_F_RST 1
`define CE_F_EN 0
`define CE_F_CNT 15:0
`define CE_F_DONE 1
`define CE_F_BERR 0

`define CE_CTL_RST 32'h2000_0000
`define CE_SEED_RST 32'hFFFF_FFFF
`define CE_RST_CYCLES 2'h3
`define CE_WORD_BYTES 16'h0004

`define CE_POLY_CCITT 32'h1021_0000
`define CE_POLY_8 32'h0700_0000
`define CE_POLY_16 32'h8005_0000
`define CE_POLY_32 32'h04C1_1DB7

`endif

// *** src/ce_pkg.sv ***
// Types shared by the CRC engine and its fold unit.
// Assumes nothing of its surroundings.
package ce_pkg;

    typedef enum logic [1:0] {
        CE_IDLE = 2'b01,
        CE_READ = 2'b10
    } ce_state_e;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] wlen;
        logic rinv;
        logic iinv;
        logic rflip;
        logic iflip;
        logic trig;
        logic rst;
        logic en;
    } ce_ctl_s;

    typedef struct packed {
        logic req;
        logic [31:0] addr;
    } ce_dma_req_s;

    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } ce_dma_rsp_s;

    typedef struct packed {
        ce_state_e st;
        ce_ctl_s ctl;
        logic [31:0] src;
        logic [15:0] bcnt;
        logic [31:0] cur;
        logic [31:0] addr;
        logic [15:0] rem;
        logic done;
        logic berr;
        logic [31:0] wdata;
        logic [31:0] seed;
        logic [31:0] crc;
        logic [31:0] rdata;
        logic slverr;
        logic [1:0] rcnt;
    } ce_regs_s;

endpackage
